//--- hdl/disp_out_params.svh
/*
 * Constants of the display output stage: register offsets, field positions,
 * reset values and pipeline figures.
 * Assumes inclusion by the package, the display output module and the checker and bench files.
 */
`ifndef DISP_OUT_PARAMS_SVH
`define DISP_OUT_PARAMS_SVH

// Register offsets (byte addresses, one 32-bit word each).
`define OFS_CONFIG      8'h04
`define OFS_COLOR_KEY   8'h08
`define OFS_COLOR_MASK  8'h0c
`define OFS_GAMMA_WRITE 8'h10

// Reset values.
`define CONFIG_RESET    32'h00000000
`define KEY_RESET       24'h000000
`define MASK_RESET      24'h000000

// Configuration register fields.
`define B_LINK_IN       31
`define B_PANEL_ON      27
`define B_GFX16         25
`define B_LINK_OE       24
`define B_LINK_DATA     23
`define B_LINK_CLK      22
`define B_GAMMA_SEL     21
`define B_KEY_SEL       20
`define F_SEQ_HI        19
`define F_SEQ_LO        17
`define F_SKEW_HI       16
`define F_SKEW_LO       14
`define B_DITHER        13
`define B_EVEN_STROBE   12
`define B_PVPOL         11
`define B_PHPOL         10
`define B_CVPOL         9
`define B_CHPOL         8
`define B_DATA_EN       7
`define B_PWR_EN        6
`define B_DAC_PWR       5
`define B_DAC_BLANK     3
`define B_CRT_VEN       2
`define B_CRT_HEN       1
`define B_DISP_EN       0
// Bits that software can write; the rest are read-only or reserved.
`define CONFIG_WMASK    32'h03ffffef

// Gamma write word: channel, index and value fields.
`define F_GCH_HI        25
`define F_GCH_LO        24
`define F_GIDX_HI       15
`define F_GIDX_LO       8
`define F_GVAL_HI       7
`define F_GVAL_LO       0

// Timing and sizes.
`define SKEW_TAPS       8
`define SKEW_BASE       3'h4
`define GAMMA_DEPTH     256
`define SEQ_MIN         3'h1
`define FRAME_CNT_ZERO  3'h0

`endif

//--- hdl/disp_out_pkg.sv
/*
 * Types of the display output stage.
 * Assumes the constants header is on the include path.
 */
`include "disp_out_params.svh"

package disp_out_pkg;

	// Panel power sequencer states.
	typedef enum logic [2:0]
	{
		SEQ_OFF,
		SEQ_UP_DATA,
		SEQ_UP_BKL,
		SEQ_ON,
		SEQ_DN_DATA,
		SEQ_DN_VDD
	} seq_state_type;

endpackage : disp_out_pkg

//--- hdl/disp_out.sv
/*
 * Display output stage: gamma lookup, colour-key merge, CRT and panel
 * timing outputs, dithering, monitor link and panel power sequencing.
 * Assumes one pixel clock on which pixels and display timing arrive, and
 * a register port whose read data appear one cycle after the strobe.
 */
// What this block does
// - Three-channel 256x8 gamma memory corrects one stream.
// - Other stream bypasses; colour key picks per pixel.
// - Bit 21 picks which stream skips gamma.
// - Bit 20 picks which stream is keyed.
// - Bit 24 turns link data pin to output.
// - Bits 23, 22 drive link data and clock.
// - Bit 31 reads sampled link data pin.
// - Bit 27 shows panel on after sequence ends.
// - Bits 19:17 give frames between power stages.
// - Bits 16:14 skew CRT syncs; 100 is baseline.
// - Bit 13 dithers 24-bit data to 18 bits.
// - Bit 12 enables even-pixel strobe output.
// - Bits 11..8 set the four sync polarities.
// - Bit 7 low holds panel data low.
// - Bit 6 rise powers up, fall powers down.
// - Up: supply, then data and syncs, then backlight.
// - Down: backlight, then data, then supply.
// - Bit 5 low powers down the converters.
// - Bit 3 low blanks converters continuously.
// - Bits 2, 1 enable CRT vertical, horizontal sync.
// - Bit 0 low holds display logic in reset.
// - Zero mask bits are ignored in key compare.
`timescale 1ns/1ns
`default_nettype none
`include "disp_out_params.svh"

module disp_out
	import disp_out_pkg::*;
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_reset_n,
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic [31:0] i_reg_wdata,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	output logic      [31:0] o_reg_rdata,
	input  wire logic [23:0] i_gfx_pixel,
	input  wire logic [23:0] i_vid_pixel,
	input  wire logic        i_hsync,
	input  wire logic        i_vsync,
	input  wire logic        i_active,
	output logic      [23:0] o_dac_rgb,
	output logic             o_dac_blank,
	output logic             o_dac_power_up,
	output logic             o_crt_hsync,
	output logic             o_crt_vsync,
	output logic      [17:0] o_panel_pixel_bus,
	output logic             o_panel_hsync,
	output logic             o_panel_vsync,
	output logic             o_panel_display_enable,
	output logic             o_panel_even_pixel_strobe,
	output logic             o_panel_supply_enable,
	output logic             o_panel_backlight_enable,
	output logic             o_gfx16_enable,
	input  wire logic        i_monitor_link_data_pin,
	output logic             o_monitor_link_data_pin,
	output logic             o_monitor_link_data_pin_oe_n,
	output logic             o_monitor_link_clock
);

	// Saturating add of a two-bit dither step, then cut to six bits.
	function automatic logic [5:0] dither_chan(input logic [7:0] c, input logic [1:0] step);
		logic [8:0] sum;
		sum = {1'b0, c} + {7'h00, step};
		dither_chan = sum[8] ? 6'h3f : sum[7:2];
	endfunction : dither_chan

	logic [31:0] config_q;
	logic [23:0] key_q;
	logic [23:0] mask_q;
	logic        link_meta_q;
	logic        link_in_q;
	logic        panel_on_q;
	logic        disp_run;
	logic [7:0]  gamma_mem [0:2][0:`GAMMA_DEPTH-1];
	logic [2:0]  seq_delay;
	logic [2:0]  skew;

	assign disp_run  = config_q[`B_DISP_EN];
	assign skew      = config_q[`F_SKEW_HI:`F_SKEW_LO];
	// Code 000 is not valid; it is run as one frame so the sequence never stalls.
	assign seq_delay = (config_q[`F_SEQ_HI:`F_SEQ_LO] == `FRAME_CNT_ZERO) ? `SEQ_MIN
	                 : config_q[`F_SEQ_HI:`F_SEQ_LO];

	// Register writes; read-only and reserved bits are never stored.
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
		begin
			config_q <= `CONFIG_RESET;
			key_q    <= `KEY_RESET;
			mask_q   <= `MASK_RESET;
		end
		else if (i_reg_wr)
		begin
			case (i_reg_addr)
				`OFS_CONFIG:     config_q <= i_reg_wdata & `CONFIG_WMASK;
				`OFS_COLOR_KEY:  key_q    <= i_reg_wdata[23:0];
				`OFS_COLOR_MASK: mask_q   <= i_reg_wdata[23:0];
				default:         ;
			endcase
		end
	end

	// Gamma memory loads one entry of one channel per write.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_reg_wr && i_reg_addr == `OFS_GAMMA_WRITE
		    && i_reg_wdata[`F_GCH_HI:`F_GCH_LO] != 2'h3)
			gamma_mem[i_reg_wdata[`F_GCH_HI:`F_GCH_LO]][i_reg_wdata[`F_GIDX_HI:`F_GIDX_LO]]
				<= i_reg_wdata[`F_GVAL_HI:`F_GVAL_LO];
	end

	// Register reads; unmapped offsets and write-only words read zero.
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
			o_reg_rdata <= 32'h00000000;
		else if (i_reg_rd)
		begin
			case (i_reg_addr)
				`OFS_CONFIG:
				begin
					o_reg_rdata              <= config_q;
					o_reg_rdata[`B_LINK_IN]  <= link_in_q;
					o_reg_rdata[`B_PANEL_ON] <= panel_on_q;
				end
				`OFS_COLOR_KEY:  o_reg_rdata <= {8'h00, key_q};
				`OFS_COLOR_MASK: o_reg_rdata <= {8'h00, mask_q};
				default:         o_reg_rdata <= 32'h00000000;
			endcase
		end
		else
			o_reg_rdata <= 32'h00000000;
	end

	// Two-flop synchroniser for the monitor link data pin.
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
		begin
			link_meta_q <= 1'b0;
			link_in_q   <= 1'b0;
		end
		else
		begin
			link_meta_q <= i_monitor_link_data_pin;
			link_in_q   <= link_meta_q;
		end
	end

	// Monitor link pins and static controls follow the register directly.
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
		begin
			o_monitor_link_data_pin      <= 1'b0;
			o_monitor_link_data_pin_oe_n <= 1'b1;
			o_monitor_link_clock         <= 1'b0;
			o_dac_power_up               <= 1'b0;
			o_gfx16_enable               <= 1'b0;
		end
		else
		begin
			o_monitor_link_data_pin      <= config_q[`B_LINK_DATA];
			o_monitor_link_data_pin_oe_n <= !config_q[`B_LINK_OE];
			o_monitor_link_clock         <= config_q[`B_LINK_CLK];
			o_dac_power_up               <= config_q[`B_DAC_PWR];
			o_gfx16_enable               <= config_q[`B_GFX16];
		end
	end

	// Pixel stage one: capture both streams and the masked key match.
	logic [23:0] gfx_s1_q;
	logic [23:0] vid_s1_q;
	logic        match_s1_q;
	logic [23:0] keyed;

	assign keyed = config_q[`B_KEY_SEL] ? i_vid_pixel : i_gfx_pixel;

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n || !disp_run)
		begin
			gfx_s1_q   <= 24'h000000;
			vid_s1_q   <= 24'h000000;
			match_s1_q <= 1'b0;
		end
		else
		begin
			gfx_s1_q   <= i_gfx_pixel;
			vid_s1_q   <= i_vid_pixel;
			match_s1_q <= ((keyed ^ key_q) & mask_q) == 24'h000000;
		end
	end

	// Pixel stage two: gamma lookup of one stream, bypass of the other.
	logic [23:0] corr_in;
	logic [23:0] corr_s2_q;
	logic [23:0] byp_s2_q;
	logic        match_s2_q;

	assign corr_in = config_q[`B_GAMMA_SEL] ? vid_s1_q : gfx_s1_q;

	genvar ch;
	generate
		for (ch = 0; ch < 3; ch++)
		begin : g_gamma
			always_ff @(posedge i_sys_clk)
			begin
				corr_s2_q[ch*8 +: 8] <= gamma_mem[ch][corr_in[ch*8 +: 8]];
			end
		end
	endgenerate

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n || !disp_run)
		begin
			byp_s2_q   <= 24'h000000;
			match_s2_q <= 1'b0;
		end
		else
		begin
			byp_s2_q   <= config_q[`B_GAMMA_SEL] ? gfx_s1_q : vid_s1_q;
			match_s2_q <= match_s1_q;
		end
	end

	// Pixel stage three: a key match shows video, otherwise graphics.
	logic [23:0] mix_s3_q;
	logic [23:0] gfx_s2;
	logic [23:0] vid_s2;

	assign gfx_s2 = config_q[`B_GAMMA_SEL] ? byp_s2_q : corr_s2_q;
	assign vid_s2 = config_q[`B_GAMMA_SEL] ? corr_s2_q : byp_s2_q;

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n || !disp_run)
			mix_s3_q <= 24'h000000;
		else
			mix_s3_q <= match_s2_q ? vid_s2 : gfx_s2;
	end

	// Timing history; tap k holds the timing k+1 pixel clocks old.
	logic [`SKEW_TAPS-1:0] hs_hist_q;
	logic [`SKEW_TAPS-1:0] vs_hist_q;
	logic [`SKEW_TAPS-1:0] act_hist_q;

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n || !disp_run)
		begin
			hs_hist_q  <= '0;
			vs_hist_q  <= '0;
			act_hist_q <= '0;
		end
		else
		begin
			hs_hist_q  <= {hs_hist_q[`SKEW_TAPS-2:0], i_hsync};
			vs_hist_q  <= {vs_hist_q[`SKEW_TAPS-2:0], i_vsync};
			act_hist_q <= {act_hist_q[`SKEW_TAPS-2:0], i_active};
		end
	end

	// Pixel and dither position for the ordered 2x2 pattern.
	logic px_odd_q;
	logic line_odd_q;
	logic [1:0] step;

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n || !disp_run)
		begin
			px_odd_q   <= 1'b0;
			line_odd_q <= 1'b0;
		end
		else
		begin
			px_odd_q <= act_hist_q[2] ? !px_odd_q : 1'b0;
			if (hs_hist_q[2] && !hs_hist_q[3])
				line_odd_q <= !line_odd_q;
		end
	end

	assign step = {px_odd_q ^ line_odd_q, line_odd_q};

	// CRT outputs: data aligned at the baseline tap, syncs at the skew tap.
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n || !disp_run)
		begin
			o_dac_rgb   <= 24'h000000;
			o_dac_blank <= 1'b1;
			o_crt_hsync <= config_q[`B_CHPOL];
			o_crt_vsync <= config_q[`B_CVPOL];
		end
		else
		begin
			o_dac_rgb   <= mix_s3_q;
			o_dac_blank <= !config_q[`B_DAC_BLANK] || !act_hist_q[`SKEW_BASE - 3'h1];
			o_crt_hsync <= (config_q[`B_CRT_HEN] && hs_hist_q[skew - 3'h1])
			               ^ config_q[`B_CHPOL];
			o_crt_vsync <= (config_q[`B_CRT_VEN] && vs_hist_q[skew - 3'h1])
			               ^ config_q[`B_CVPOL];
		end
	end

	// Panel sequencer: frames counted on vertical sync starts.
	seq_state_type seq_q;
	logic [2:0] frame_cnt_q;
	logic       pwr_en_q;
	logic       data_stage_q;
	logic       vs_start;
	logic       frame_done;

	assign vs_start   = vs_hist_q[0] && !vs_hist_q[1];
	assign frame_done = vs_start && (frame_cnt_q + 3'h1 >= seq_delay);

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
		begin
			seq_q                    <= SEQ_OFF;
			frame_cnt_q              <= `FRAME_CNT_ZERO;
			pwr_en_q                 <= 1'b0;
			data_stage_q             <= 1'b0;
			panel_on_q               <= 1'b0;
			o_panel_supply_enable    <= 1'b0;
			o_panel_backlight_enable <= 1'b0;
		end
		else
		begin
			pwr_en_q <= config_q[`B_PWR_EN];
			if (config_q[`B_PWR_EN] && !pwr_en_q)
			begin
				o_panel_supply_enable <= 1'b1;
				frame_cnt_q           <= `FRAME_CNT_ZERO;
				seq_q                 <= data_stage_q ? SEQ_UP_BKL : SEQ_UP_DATA;
			end
			else if (!config_q[`B_PWR_EN] && pwr_en_q)
			begin
				o_panel_backlight_enable <= 1'b0;
				frame_cnt_q              <= `FRAME_CNT_ZERO;
				seq_q                    <= data_stage_q ? SEQ_DN_DATA : SEQ_DN_VDD;
			end
			else
			begin
				if (vs_start)
					frame_cnt_q <= frame_done ? `FRAME_CNT_ZERO : frame_cnt_q + 3'h1;
				case (seq_q)
					SEQ_UP_DATA:
						if (frame_done)
						begin
							data_stage_q <= 1'b1;
							seq_q        <= SEQ_UP_BKL;
						end
					SEQ_UP_BKL:
						if (frame_done)
						begin
							o_panel_backlight_enable <= 1'b1;
							panel_on_q               <= 1'b1;
							seq_q                    <= SEQ_ON;
						end
					SEQ_DN_DATA:
						if (frame_done)
						begin
							data_stage_q <= 1'b0;
							seq_q        <= SEQ_DN_VDD;
						end
					SEQ_DN_VDD:
						if (frame_done)
						begin
							o_panel_supply_enable <= 1'b0;
							panel_on_q            <= 1'b0;
							seq_q                 <= SEQ_OFF;
						end
					SEQ_OFF, SEQ_ON: ;
					default: seq_q <= SEQ_OFF;
				endcase
			end
		end
	end

	// Panel outputs: data and syncs only while the data stage is up.
	logic panel_go;

	assign panel_go = disp_run && data_stage_q;

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n || !panel_go)
		begin
			o_panel_pixel_bus         <= 18'h00000;
			o_panel_hsync             <= 1'b0;
			o_panel_vsync             <= 1'b0;
			o_panel_display_enable    <= 1'b0;
			o_panel_even_pixel_strobe <= 1'b0;
		end
		else
		begin
			if (!config_q[`B_DATA_EN])
				o_panel_pixel_bus <= 18'h00000;
			else if (config_q[`B_DITHER])
				o_panel_pixel_bus <= {dither_chan(mix_s3_q[23:16], step),
				                      dither_chan(mix_s3_q[15:8], step),
				                      dither_chan(mix_s3_q[7:0], step)};
			else
				o_panel_pixel_bus <= {mix_s3_q[23:18], mix_s3_q[15:10], mix_s3_q[7:2]};
			o_panel_hsync             <= hs_hist_q[`SKEW_BASE - 3'h1] ^ config_q[`B_PHPOL];
			o_panel_vsync             <= vs_hist_q[`SKEW_BASE - 3'h1] ^ config_q[`B_PVPOL];
			o_panel_display_enable    <= act_hist_q[`SKEW_BASE - 3'h1];
			o_panel_even_pixel_strobe <= config_q[`B_EVEN_STROBE] && act_hist_q[`SKEW_BASE - 3'h1]
			                             && !px_odd_q;
		end
	end

endmodule : disp_out
`default_nettype wire

//--- testbench/disp_out_sva.sv
/* Checker for the display output stage: register port, control outputs and panel sequencing.
   Assumes the top module's ports only and a shadow of the configuration word kept here. */
`timescale 1ns/1ns
`default_nettype none
`include "disp_out_params.svh"

module disp_out_sva
(
	input wire logic        i_sys_clk,
	input wire logic        i_reset_n,
	input wire logic [7:0]  i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic        i_reg_wr,
	input wire logic        i_reg_rd,
	input wire logic [31:0] o_reg_rdata,
	input wire logic        o_dac_blank,
	input wire logic        o_dac_power_up,
	input wire logic        o_crt_vsync,
	input wire logic [17:0] o_panel_pixel_bus,
	input wire logic        o_panel_supply_enable,
	input wire logic        o_panel_backlight_enable,
	input wire logic        o_gfx16_enable,
	input wire logic        o_monitor_link_data_pin,
	input wire logic        o_monitor_link_data_pin_oe_n,
	input wire logic        o_monitor_link_clock
);
	logic [31:0] cfg_q;

	// Shadow of the configuration word, updated on every write to it.
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
			cfg_q <= 32'h00000000;
		else if (i_reg_wr && i_reg_addr == `OFS_CONFIG)
			cfg_q <= i_reg_wdata;
	end

	default clocking dc @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_reset_n);

	// Read data are zero except in the cycle after a read.
	rdata_idle_a: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h00000000)
		else $error("read data outside the answer cycle");
	link_pins_a: assert property ({o_monitor_link_data_pin_oe_n, o_monitor_link_data_pin, o_monitor_link_clock} ==
		{!$past(cfg_q[24]), $past(cfg_q[23]), $past(cfg_q[22])}) else $error("link pins differ from setting");
	ctrl_levels_a: assert property ({o_gfx16_enable, o_dac_power_up} == {$past(cfg_q[25]), $past(cfg_q[5])})
		else $error("converter power or width level wrong");
	// Blanking holds while converters are forced blank or display logic is reset.
	blank_hold_a: assert property ((!cfg_q[3] || !cfg_q[0]) && $stable(cfg_q) |-> o_dac_blank)
		else $error("converters not blanked");
	panel_bus_off_a: assert property (!cfg_q[7] && $stable(cfg_q) |-> o_panel_pixel_bus == 18'h00000)
		else $error("panel bus not held low");
	crt_vsync_off_a: assert property (!cfg_q[2] && $stable(cfg_q) |-> o_crt_vsync == cfg_q[9])
		else $error("disabled vertical sync not idle");
	// Sequencer edges: supply leads on power-up, backlight leads on power-down.
	supply_up_a: assert property ($rose(cfg_q[6]) |-> ##[1:3] o_panel_supply_enable)
		else $error("supply did not start power-up");
	bkl_down_a: assert property ($fell(cfg_q[6]) |-> ##[1:3] !o_panel_backlight_enable)
		else $error("backlight did not drop first");
	stage_order_a: assert property (o_panel_backlight_enable |-> o_panel_supply_enable)
		else $error("backlight without supply");

	cover property ($rose(o_panel_backlight_enable));
	cover property ($fell(o_panel_supply_enable));
	cover property (o_reg_rdata[31]);
endmodule : disp_out_sva

bind disp_out disp_out_sva u_sva
(
	.i_sys_clk                   (i_sys_clk),
	.i_reset_n                   (i_reset_n),
	.i_reg_addr                  (i_reg_addr),
	.i_reg_wdata                 (i_reg_wdata),
	.i_reg_wr                    (i_reg_wr),
	.i_reg_rd                    (i_reg_rd),
	.o_reg_rdata                 (o_reg_rdata),
	.o_dac_blank                 (o_dac_blank),
	.o_dac_power_up              (o_dac_power_up),
	.o_crt_vsync                 (o_crt_vsync),
	.o_panel_pixel_bus           (o_panel_pixel_bus),
	.o_panel_supply_enable       (o_panel_supply_enable),
	.o_panel_backlight_enable    (o_panel_backlight_enable),
	.o_gfx16_enable              (o_gfx16_enable),
	.o_monitor_link_data_pin     (o_monitor_link_data_pin),
	.o_monitor_link_data_pin_oe_n(o_monitor_link_data_pin_oe_n),
	.o_monitor_link_clock        (o_monitor_link_clock)
);
`default_nettype wire

//--- testbench/disp_out_monitor.sv
/* Monitor end of the link data line: open drain with a pull-up.
   Assumes the bench says when the monitor pulls the line low. */
`timescale 1ns/1ns
`default_nettype none

module disp_out_monitor
(
	input  wire logic i_data,
	input  wire logic i_oe_n,
	input  wire logic i_pull_low,
	output logic      o_level
);
	// Released by the device, the line rises to the pull-up unless pulled low.
	assign o_level = (i_oe_n | i_data) & !i_pull_low;
endmodule : disp_out_monitor
`default_nettype wire

//--- testbench/disp_out_bench.sv
/* Self-checking bench for the display output stage.
   Assumes the design, its header and the monitor model are compiled first. */
`timescale 1ns/1ns
`default_nettype none
`include "disp_out_params.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; $display("BAD %0t %h vs %h", $time, g, e); end end

module disp_out_bench;
	logic        i_sys_clk = 1'b0;
	logic        i_reset_n = 1'b0;
	logic [7:0]  addr      = 8'h00;
	logic [31:0] wdata     = 32'h00000000;
	logic        wr        = 1'b0;
	logic        rd        = 1'b0;
	logic [23:0] gfx       = 24'haabbcc;
	logic [23:0] vid       = 24'h123456;
	logic        hs        = 1'b0;
	logic [17:0] pbus;
	logic        pde, pstr;
	logic        vs        = 1'b0;
	logic        vs_last   = 1'b0;
	logic        frames    = 1'b0;
	logic        pull_low  = 1'b0;
	logic [31:0] rdata;
	logic [23:0] rgb;
	logic        blank, crt_h, supply, bkl, pin, pin_out, oe_n, link_clk;
	int          fail_count = 0;
	int          num_checks = 0;
	int          vs_rises   = 0;
	int          fcnt       = 0;
	int          n0;

	// Free-running 100 MHz clock.
	initial forever #5 i_sys_clk = ~i_sys_clk;

	// Frames of 40 cycles with a 4-cycle vertical sync; rises are counted.
	always @(posedge i_sys_clk)
	begin
		fcnt <= frames ? (fcnt + 1) % 40 : 0;
		vs <= frames && fcnt < 4;
		vs_last <= vs;
		if (vs && !vs_last)
			vs_rises <= vs_rises + 1;
	end

	disp_out dut
	(
		.i_sys_clk                   (i_sys_clk),
		.i_reset_n                   (i_reset_n),
		.i_reg_addr                  (addr),
		.i_reg_wdata                 (wdata),
		.i_reg_wr                    (wr),
		.i_reg_rd                    (rd),
		.o_reg_rdata                 (rdata),
		.i_gfx_pixel                 (gfx),
		.i_vid_pixel                 (vid),
		.i_hsync                     (hs),
		.i_vsync                     (vs),
		.i_active                    (1'b1),
		.o_dac_rgb                   (rgb),
		.o_dac_blank                 (blank),
		.o_dac_power_up              (),
		.o_crt_hsync                 (crt_h),
		.o_crt_vsync                 (),
		.o_panel_pixel_bus           (pbus),
		.o_panel_hsync               (),
		.o_panel_vsync               (),
		.o_panel_display_enable      (pde),
		.o_panel_even_pixel_strobe   (pstr),
		.o_panel_supply_enable       (supply),
		.o_panel_backlight_enable    (bkl),
		.o_gfx16_enable              (),
		.i_monitor_link_data_pin     (pin),
		.o_monitor_link_data_pin     (pin_out),
		.o_monitor_link_data_pin_oe_n(oe_n),
		.o_monitor_link_clock        (link_clk)
	);

	disp_out_monitor monitor
	(
		.i_data    (pin_out),
		.i_oe_n    (oe_n),
		.i_pull_low(pull_low),
		.o_level   (pin)
	);

	// One-cycle write strobe, then one idle cycle.
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge i_sys_clk);
		wr <= 1'b0;
		@(posedge i_sys_clk);
	endtask : wr_reg

	// Read strobe; the data stand only in the following cycle.
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
		addr <= a;
		rd <= 1'b1;
		@(posedge i_sys_clk);
		rd <= 1'b0;
		#1;
		`CHK(rdata, e)
		@(posedge i_sys_clk);
	endtask : rd_reg

	// Write, let the four-stage pixel path refill, then check the merged pixel.
	task automatic px(input logic [7:0] a, input logic [31:0] d, input logic [23:0] e);
		wr_reg(a, d);
		repeat (6) @(posedge i_sys_clk);
		#1;
		`CHK(rgb, e)
	endtask : px

	// Bounded wait for the backlight and supply levels.
	task automatic wait_pwr(input logic [1:0] v);
		int n;
		n = 0;
		while ({bkl, supply} !== v && n < 1000)
		begin
			@(posedge i_sys_clk);
			#1;
			n++;
		end
		`CHK({bkl, supply}, v)
	endtask : wait_pwr

	// One-cycle line sync pulse; counts edges until the CRT sync follows it.
	task automatic skew_chk(input logic [2:0] c, input int e);
		int n;
		wr_reg(`OFS_CONFIG, {15'h0000, c, 14'h0003});
		repeat (8) @(posedge i_sys_clk);
		hs <= 1'b1;
		@(posedge i_sys_clk);
		hs <= 1'b0;
		n = 1;
		while (!crt_h && n < 20)
		begin
			@(posedge i_sys_clk);
			#1;
			n++;
		end
		`CHK(n, e)
	endtask : skew_chk

	// Prints the counts and the verdict, then stops.
	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test

	// Watchdog: the tests need about 430 cycles.
	initial
	begin
		repeat (20000) @(posedge i_sys_clk);
		fail_count++;
		end_of_test();
	end

	initial
	begin
		repeat (6) @(posedge i_sys_clk);
		i_reset_n <= 1'b1;
		// The link pin needs two more edges to pass its synchroniser.
		repeat (3) @(posedge i_sys_clk);
		rd_reg(`OFS_CONFIG, 32'h80000000);
		rd_reg(8'h20, 32'h00000000);
		rd_reg(`OFS_GAMMA_WRITE, 32'h00000000);
		// Link pin driven low, then released while the monitor pulls it low.
		wr_reg(`OFS_CONFIG, 32'h01400000);
		repeat (3) @(posedge i_sys_clk);
		`CHK({oe_n, pin_out, link_clk}, 3'b001)
		rd_reg(`OFS_CONFIG, 32'h01400000);
		wr_reg(`OFS_CONFIG, 32'h00800000);
		pull_low <= 1'b1;
		repeat (3) @(posedge i_sys_clk);
		rd_reg(`OFS_CONFIG, 32'h00800000);
		pull_low <= 1'b0;
		// Mask zero matches every pixel, so video shows through the bypass.
		px(`OFS_CONFIG, 32'h0000010b, vid);
		`CHK({blank, crt_h}, 2'b01)
		wr_reg(`OFS_COLOR_MASK, 32'h00ffffff);
		wr_reg(`OFS_GAMMA_WRITE, 32'h0200aa11);
		wr_reg(`OFS_GAMMA_WRITE, 32'h0100bb22);
		wr_reg(`OFS_GAMMA_WRITE, 32'h02001244);
		wr_reg(`OFS_GAMMA_WRITE, 32'h01003455);
		wr_reg(`OFS_GAMMA_WRITE, 32'h00005666);
		px(`OFS_GAMMA_WRITE, 32'h0000cc33, 24'h112233);
		wr_reg(`OFS_COLOR_KEY, 32'h00123456);
		px(`OFS_CONFIG, 32'h0030010b, 24'h445566);
		px(`OFS_CONFIG, 32'h0020010b, gfx);
		wr_reg(`OFS_COLOR_KEY, 32'h00ffffcc);
		px(`OFS_COLOR_MASK, 32'h000000ff, 24'h445566);
		px(`OFS_CONFIG, 32'h0020010a, 24'h000000);
		`CHK(blank, 1'b1)
		// Power-up two frames a stage, started while the frame timing stands.
		wr_reg(`OFS_CONFIG, 32'h000400e9);
		wait_pwr(2'b01);
		n0 = vs_rises;
		frames <= 1'b1;
		wait_pwr(2'b11);
		`CHK(vs_rises - n0, 4)
		rd_reg(`OFS_CONFIG, 32'h880400e9);
		`CHK({pbus, pde, pstr}, {18'h04355, 2'b10})
		// Dither and even strobe alternate with the pixel phase.
		wr_reg(`OFS_CONFIG, 32'h000430e9);
		repeat (2) @(posedge i_sys_clk);
		#1;
		n0 = pstr;
		`CHK(pbus, (n0 != 0) ? 18'h04355 : 18'h05356)
		@(posedge i_sys_clk);
		#1;
		`CHK({pbus, pstr}, {(n0 != 0) ? 18'h05356 : 18'h04355, n0 == 0})
		wr_reg(`OFS_CONFIG, 32'h000400a9);
		wait_pwr(2'b01);
		n0 = vs_rises;
		wait_pwr(2'b00);
		`CHK(vs_rises - n0, 4)
		rd_reg(`OFS_CONFIG, 32'h800400a9);
		frames <= 1'b0;
		skew_chk(3'h4, 5);
		skew_chk(3'h6, 7);
		skew_chk(3'h2, 3);
		wr_reg(`OFS_CONFIG, 32'hffffffff);
		rd_reg(`OFS_CONFIG, 32'h80000000 | `CONFIG_WMASK);
		end_of_test();
	end
endmodule : disp_out_bench
`default_nettype wire
